// ==== hw/eam_pkg.sv ====
// Shared constants and types for the event arbitration and message frame link
package eam_pkg;
  // ==========================================================================
  // Frame fields
  localparam int          FC_W          = 4;
  localparam int          NODE_W        = 12;
  localparam int          WORD_W        = 16;
  localparam int          BYTE_W        = 8;
  localparam int          FC_LSB        = 12;
  localparam int          MODE_LSB      = 8;
  localparam int          CLASS_LSB     = 4;
  localparam int          SCOPE_LSB     = 4;
  localparam int          TGT_HI_LSB    = 0;
  localparam int          TGT_LO_LSB    = 8;
  localparam logic [3:0]  FC_START      = 4'h9;
  localparam logic [3:0]  FC_GROUP      = 4'hD;
  localparam logic [3:0]  FC_INDIV      = 4'hE;
  localparam logic [3:0]  FC_MSG        = 4'hC;
  localparam logic [3:0]  MODE_CONT     = 4'h0;
  localparam logic [3:0]  MODE_START    = 4'h1;
  localparam logic [3:0]  MODE_SWITCH   = 4'h2;
  localparam logic [3:0]  MODE_SILENT   = 4'h3;
  localparam logic [3:0]  CLASS_MAX     = 4'h1;
  localparam int          MSG_WORDS_DEF = 16;
  // ==========================================================================
  // Admin register map and fields
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_EVSINK    = 8'h08;
  localparam logic [7:0]  REG_LASTWORD  = 8'h0C;
  localparam int          CMD_RETURN_EF = 16;
  localparam int          ST_BUSY       = 0;
  localparam int          ST_GOT        = 1;
  localparam int          ST_TIMEOUT    = 2;
  localparam int          ST_CNT_LSB    = 8;
  localparam int          CNT_W         = 5;
  // ==========================================================================
  // Timing
  localparam int          CLK_NS        = 50;
  localparam int          REPLY_TO_NS   = 2000;
  localparam int          REPLY_TO_CYC  = (REPLY_TO_NS + CLK_NS - 1) / CLK_NS;
  localparam int          TMR_W         = 12;
  // ==========================================================================
  // States
  typedef enum logic [1:0] {
    EAM_IDLE = 2'b01,
    EAM_BUSY = 2'b10
  } eam_state_type;
endpackage

// ==== hw/eam_link_if.sv ====
// Frame level link between bus administrator and slave device
`timescale 1ns/1ns
`default_nettype none
interface eam_link_if;
  // Master frame word, one-cycle strobe
  logic        mf_valid;
  logic [15:0] mf_word;
  // Slave frame as bytes, low byte of each word first
  logic        sf_valid;
  logic [7:0]  sf_byte;
  logic        sf_last;
  modport dev   (input mf_valid, input mf_word, output sf_valid, output sf_byte, output sf_last);
  modport admin (output mf_valid, output mf_word, input sf_valid, input sf_byte, input sf_last);
endinterface
`default_nettype wire

// ==== hw/eam_device.sv ====
// Slave device end: event poll interpretation, event flags and message source
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module eam_device #(
  parameter int MSG_WORDS = eam_pkg::MSG_WORDS_DEF
) (
  input  wire logic                        CLOCK_I,
  input  wire logic                        ARST_N_I,
  eam_link_if.dev                          LINK,
  input  wire logic [eam_pkg::NODE_W-1:0]  OWN_NODE_NUMBER_I,
  input  wire logic                        EVENT_POLL_ENABLE_I,
  input  wire logic                        HI_SRC_ACTIVE_I,
  input  wire logic [eam_pkg::WORD_W-1:0]  HI_SRC_WORD_I,
  input  wire logic                        LO_SRC_ACTIVE_I,
  input  wire logic [eam_pkg::WORD_W-1:0]  LO_SRC_WORD_I,
  input  wire logic                        SINK_ACTIVE_I,
  input  wire logic [1:0]                  ANNOUNCE_I,
  input  wire logic                        CANCEL_EVENT_BIT_HI_I,
  input  wire logic                        CANCEL_EVENT_BIT_LO_I,
  input  wire logic                        MSG_SRC_ACTIVE_I,
  input  wire logic [1:0]                  MSG_DROP_ON_SEND_I,
  input  wire logic                        MSG_WR_I,
  input  wire logic [$clog2(MSG_WORDS)-1:0] MSG_WR_ADDR_I,
  input  wire logic [eam_pkg::WORD_W-1:0]  MSG_WR_DATA_I,
  input  wire logic                        OTHER_SENT_I,
  input  wire logic [1:0]                  OTHER_DROP_ON_SEND_I,
  output logic      [1:0]                  EVENT_PENDING_O,
  output logic      [1:0]                  ROUND_JOINED_O,
  output logic                             EVENT_CLASS_O,
  output logic                             SINK_VALID_O,
  output logic      [eam_pkg::WORD_W-1:0]  SINK_WORD_O,
  output logic      [3:0]                  MSG_SCOPE_O,
  output logic      [eam_pkg::NODE_W-1:0]  MSG_TARGET_O,
  output logic                             MSG_SENT_O
);
  import eam_pkg::*;

  localparam int AW    = $clog2(MSG_WORDS);
  localparam int IDX_W = AW + 1;
  localparam logic [IDX_W-1:0] LAST_MSG = IDX_W'(2 * MSG_WORDS - 1);
  localparam logic [IDX_W-1:0] LAST_EVT = IDX_W'(1);

  // ==========================================================================
  // Elaboration check
  if (MSG_WORDS < 2 || (MSG_WORDS & (MSG_WORDS - 1)) != 0) begin : g_chk
    $error("MSG_WORDS must be a power of two of at least 2");
  end

  // ==========================================================================
  // Group pattern decode: leading ones, a zero, then compared low bits
  function automatic logic grp_match(input logic [NODE_W-1:0] pat, input logic [NODE_W-1:0] own);
    logic              found;
    logic              hit;
    logic [NODE_W-1:0] mask;
    found = 1'b0;
    hit   = 1'b0;
    mask  = '0;
    for (int i = NODE_W - 1; i >= 0; i--) begin
      if (!found && !pat[i]) begin
        found = 1'b1;
        mask  = NODE_W'((NODE_W'(1) << i) - NODE_W'(1));
        hit   = ((pat ^ own) & mask) == '0;
      end
    end
    return hit;
  endfunction

  // ==========================================================================
  // State
  eam_state_type         state_ff;
  logic [1:0]            pending_ff;
  logic [1:0]            joined_ff;
  logic                  class_ff;
  logic                  is_msg_ff;
  logic [IDX_W-1:0]      idx_ff;
  logic [WORD_W-1:0]     ev_word_ff;
  logic                  sf_valid_ff;
  logic [BYTE_W-1:0]     sf_byte_ff;
  logic                  sf_last_ff;
  logic                  sink_arm_ff;
  logic [BYTE_W-1:0]     sink_lo_ff;
  logic                  sink_valid_ff;
  logic [WORD_W-1:0]     sink_word_ff;
  logic [3:0]            scope_ff;
  logic [NODE_W-1:0]     target_ff;
  logic                  sent_ff;
  logic [WORD_W-1:0]     msg_mem [MSG_WORDS];

  // ==========================================================================
  // Master frame decode
  wire logic [3:0]        fc      = LINK.mf_word[FC_LSB +: FC_W];
  wire logic [NODE_W-1:0] arg     = LINK.mf_word[NODE_W-1:0];
  wire logic [3:0]        mode    = LINK.mf_word[MODE_LSB +: 4];
  wire logic [3:0]        cls_fld = LINK.mf_word[CLASS_LSB +: 4];
  wire logic              idle    = (state_ff == EAM_IDLE);
  wire logic              en      = EVENT_POLL_ENABLE_I;
  // Illegal class or mode makes the start poll invisible
  wire logic              is_start = LINK.mf_valid && fc == FC_START
                                     && cls_fld <= CLASS_MAX
                                     && mode <= MODE_SILENT;
  wire logic              is_group = LINK.mf_valid && fc == FC_GROUP;
  wire logic              is_indiv = LINK.mf_valid && fc == FC_INDIV;
  wire logic              is_msg   = LINK.mf_valid && fc == FC_MSG;
  wire logic              new_cls  = cls_fld[0];

  // Reply class is the new one on a start poll, the stored one otherwise
  wire logic              rep_cls  = is_start ? new_cls : class_ff;
  wire logic              src_ok   = en && (rep_cls ? LO_SRC_ACTIVE_I : HI_SRC_ACTIVE_I);
  wire logic [WORD_W-1:0] src_word = rep_cls ? LO_SRC_WORD_I : HI_SRC_WORD_I;

  // Start poll participation decisions, per mode
  wire logic start_join  = is_start && en && pending_ff[new_cls]
                           && (mode == MODE_START || mode == MODE_SILENT);
  wire logic start_reply = is_start && src_ok
                           && ((mode == MODE_CONT && joined_ff[new_cls])
                           || (mode == MODE_START && pending_ff[new_cls]));
  // Modes 2 and 3 never reach start_reply, so the line stays silent
  // until the administrator's reply timeout
  wire logic group_reply = is_group && src_ok && joined_ff[class_ff]
                           && grp_match(arg, OWN_NODE_NUMBER_I);
  wire logic indiv_reply = is_indiv && src_ok && joined_ff[class_ff]
                           && arg == OWN_NODE_NUMBER_I;
  wire logic msg_reply   = is_msg && MSG_SRC_ACTIVE_I
                           && arg == OWN_NODE_NUMBER_I;
  wire logic evt_reply   = start_reply || group_reply || indiv_reply;
  wire logic start_tx    = idle && (evt_reply || msg_reply);
  wire logic any_poll    = is_start || is_group || is_indiv;

  // Byte stream of the slave frame, low byte first
  wire logic [WORD_W-1:0] tx_word  = is_msg_ff ? msg_mem[idx_ff[IDX_W-1:1]] : ev_word_ff;
  wire logic [BYTE_W-1:0] tx_byte  = idx_ff[0] ? tx_word[WORD_W-1:BYTE_W] : tx_word[BYTE_W-1:0];
  wire logic              tx_last  = idx_ff == (is_msg_ff ? LAST_MSG : LAST_EVT);
  wire logic              tx_done  = (state_ff == EAM_BUSY) && tx_last;
  wire logic [1:0]        drop_clr = ({2{tx_done && is_msg_ff}} & MSG_DROP_ON_SEND_I)
                                     | ({2{OTHER_SENT_I}} & OTHER_DROP_ON_SEND_I);
  wire logic [1:0]        cancel   = {CANCEL_EVENT_BIT_LO_I, CANCEL_EVENT_BIT_HI_I};

  // ==========================================================================
  // Per-class flags; a set in the same cycle as a clear wins
  wire logic [1:0] nxt_pending;
  wire logic [1:0] nxt_joined;
  for (genvar c = 0; c < 2; c++) begin : g_cls
    wire logic join_c = start_join && new_cls == 1'(c);
    assign nxt_pending[c] = ANNOUNCE_I[c] || (pending_ff[c] && !cancel[c] && !drop_clr[c]);
    assign nxt_joined[c]  = join_c || (joined_ff[c] && !cancel[c] && !drop_clr[c]);
  end
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pending_ff <= '0;
      joined_ff  <= '0;
    end else begin
      pending_ff <= nxt_pending;
      joined_ff  <= nxt_joined;
    end
  end

  // ==========================================================================
  // Stored class, changed only by a legal start poll
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      class_ff <= 1'b0;
    end else if (is_start) begin
      class_ff <= new_cls;
    end
  end

  // ==========================================================================
  // Message buffer written by local software, no reset needed for data
  always_ff @(posedge CLOCK_I) begin
    if (MSG_WR_I) begin
      msg_mem[MSG_WR_ADDR_I] <= MSG_WR_DATA_I;
    end
  end

  // ==========================================================================
  // Transmit sequencer; frames arriving while busy are not answered
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_ff   <= EAM_IDLE;
      is_msg_ff  <= 1'b0;
      idx_ff     <= '0;
      ev_word_ff <= '0;
    end else if (start_tx) begin
      state_ff   <= EAM_BUSY;
      is_msg_ff  <= msg_reply;
      idx_ff     <= '0;
      ev_word_ff <= src_word;
    end else if (state_ff == EAM_BUSY) begin
      idx_ff     <= IDX_W'(idx_ff + IDX_W'(1));
      if (tx_last) begin
        state_ff <= EAM_IDLE;
      end
    end
  end

  // Registered link outputs, one byte per cycle
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sf_valid_ff <= 1'b0;
      sf_byte_ff  <= '0;
      sf_last_ff  <= 1'b0;
      sent_ff     <= 1'b0;
    end else begin
      sf_valid_ff <= state_ff == EAM_BUSY;
      sf_byte_ff  <= (state_ff == EAM_BUSY) ? tx_byte : '0;
      sf_last_ff  <= tx_done;
      sent_ff     <= tx_done && is_msg_ff;
    end
  end

  // ==========================================================================
  // Header of message word 0, caught when the message starts
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      scope_ff  <= '0;
      target_ff <= '0;
    end else if (start_tx && msg_reply) begin
      scope_ff  <= msg_mem[0][SCOPE_LSB +: 4];
      target_ff <= {msg_mem[0][TGT_HI_LSB +: 4], msg_mem[0][TGT_LO_LSB +: 8]};
    end
  end

  // ==========================================================================
  // Event sink: watches the event frame after a poll, pairs low then high
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sink_arm_ff   <= 1'b0;
      sink_lo_ff    <= '0;
      sink_word_ff  <= '0;
      sink_valid_ff <= 1'b0;
    end else begin
      sink_valid_ff <= 1'b0;
      if (any_poll) begin
        sink_arm_ff <= SINK_ACTIVE_I && en;
      end else if (sink_arm_ff && sf_valid_ff) begin
        if (!sf_last_ff) begin
          sink_lo_ff <= sf_byte_ff;
        end else begin
          sink_word_ff  <= {sf_byte_ff, sink_lo_ff};
          sink_valid_ff <= 1'b1;
          sink_arm_ff   <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign LINK.sf_valid    = sf_valid_ff;
  assign LINK.sf_byte     = sf_byte_ff;
  assign LINK.sf_last     = sf_last_ff;
  assign EVENT_PENDING_O  = pending_ff;
  assign ROUND_JOINED_O   = joined_ff;
  assign EVENT_CLASS_O    = class_ff;
  assign SINK_VALID_O     = sink_valid_ff;
  assign SINK_WORD_O      = sink_word_ff;
  assign MSG_SCOPE_O      = scope_ff;
  assign MSG_TARGET_O     = target_ff;
  assign MSG_SENT_O       = sent_ff;
endmodule
`default_nettype wire

// ==== hw/eam_bus_admin.sv ====
// Bus administrator end: sends master frames ordered over APB, gathers replies
`timescale 1ns/1ns
`default_nettype none
module eam_bus_admin #(
  parameter int REPLY_CYC = eam_pkg::REPLY_TO_CYC
) (
  input  wire logic        CLOCK_I,
  input  wire logic        ARST_N_I,
  eam_link_if.admin        LINK,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O
);
  import eam_pkg::*;

  // ==========================================================================
  // Elaboration check
  if (REPLY_CYC < 1 || REPLY_CYC >= (1 << TMR_W)) begin : g_chk
    $error("REPLY_CYC out of timer range");
  end

  eam_state_type     state_ff;
  logic              mf_valid_ff;
  logic [WORD_W-1:0] mf_word_ff;
  logic [TMR_W-1:0]  tmr_ff;
  logic              got_ff;
  logic              tout_ff;
  logic              evt_poll_ff;
  logic              half_ff;
  logic [BYTE_W-1:0] lo_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [WORD_W-1:0] sink_ff;
  logic [WORD_W-1:0] last_ff;
  logic [31:0]       prdata_ff;
  logic [31:0]       rd_mux;
  logic              mapped;

  // ==========================================================================
  // APB decode; no wait states
  wire logic acc     = PSEL_I && PENABLE_I;
  wire logic cmd_wr  = acc && PWRITE_I && PADDR_I == REG_CMD && state_ff == EAM_IDLE;
  wire logic [WORD_W-1:0] cmd_word = PWDATA_I[CMD_RETURN_EF] ? sink_ff : PWDATA_I[WORD_W-1:0];
  wire logic [3:0] cmd_fc = cmd_word[FC_LSB +: FC_W];
  wire logic rx_word = state_ff == EAM_BUSY && LINK.sf_valid && half_ff;
  wire logic expired = state_ff == EAM_BUSY && tmr_ff == '0;

  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    if (PADDR_I == REG_CMD) begin
      rd_mux = {16'h0000, mf_word_ff};
    end else if (PADDR_I == REG_STATUS) begin
      rd_mux = 32'(cnt_ff) << ST_CNT_LSB;
      rd_mux[ST_BUSY]    = state_ff == EAM_BUSY;
      rd_mux[ST_GOT]     = got_ff;
      rd_mux[ST_TIMEOUT] = tout_ff;
    end else if (PADDR_I == REG_EVSINK) begin
      rd_mux = {16'h0000, sink_ff};
    end else if (PADDR_I == REG_LASTWORD) begin
      rd_mux = {16'h0000, last_ff};
    end else begin
      mapped = 1'b0;
    end
  end

  // Read data caught in the setup cycle
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prdata_ff <= '0;
    end else if (PSEL_I && !PENABLE_I) begin
      prdata_ff <= rd_mux;
    end
  end

  // ==========================================================================
  // Frame sequencer: one master frame, then wait for reply or timeout
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_ff    <= EAM_IDLE;
      mf_valid_ff <= 1'b0;
      mf_word_ff  <= '0;
      tmr_ff      <= '0;
      got_ff      <= 1'b0;
      tout_ff     <= 1'b0;
      evt_poll_ff <= 1'b0;
    end else begin
      mf_valid_ff <= cmd_wr;
      if (cmd_wr) begin
        state_ff    <= EAM_BUSY;
        mf_word_ff  <= cmd_word;
        tmr_ff      <= TMR_W'(REPLY_CYC);
        got_ff      <= 1'b0;
        tout_ff     <= 1'b0;
        evt_poll_ff <= cmd_fc == FC_START || cmd_fc == FC_GROUP || cmd_fc == FC_INDIV;
      end else if (state_ff == EAM_BUSY) begin
        tmr_ff <= TMR_W'(tmr_ff - TMR_W'(1));
        if (LINK.sf_valid && LINK.sf_last) begin
          state_ff <= EAM_IDLE;
          got_ff   <= 1'b1;
        end else if (expired) begin
          state_ff <= EAM_IDLE;
          tout_ff  <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Reply assembly, low byte first; an odd trailing byte is dropped
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      half_ff <= 1'b0;
      lo_ff   <= '0;
      cnt_ff  <= '0;
      sink_ff <= '0;
      last_ff <= '0;
    end else if (cmd_wr) begin
      half_ff <= 1'b0;
      cnt_ff  <= '0;
    end else if (state_ff == EAM_BUSY && LINK.sf_valid) begin
      half_ff <= !half_ff;
      if (!half_ff) begin
        lo_ff <= LINK.sf_byte;
      end
      if (rx_word) begin
        last_ff <= {LINK.sf_byte, lo_ff};
        cnt_ff  <= CNT_W'(cnt_ff + CNT_W'(1));
        if (evt_poll_ff && cnt_ff == '0) begin
          sink_ff <= {LINK.sf_byte, lo_ff};
        end
      end
    end
  end

  assign LINK.mf_valid = mf_valid_ff;
  assign LINK.mf_word  = mf_word_ff;
  assign PRDATA_O      = prdata_ff;
  assign PREADY_O      = 1'b1;
  assign PSLVERR_O     = acc && !mapped;
endmodule
`default_nettype wire

// ==== dv/eam_link_checker.sv ====
// Frame link checker beside administrator and device
`timescale 1ns/1ns
`default_nettype none
module eam_link_checker (
  input wire logic        CLOCK_I,
  input wire logic        ARST_N_I,
  input wire logic        mf_valid,
  input wire logic [15:0] mf_word,
  input wire logic        sf_valid,
  input wire logic [7:0]  sf_byte,
  input wire logic        sf_last
);
  import eam_pkg::*;
  wire  [3:0] fc = mf_word[15:12];
  logic [5:0] cnt_ff;
  // ==========
  // Bytes already passed in the frame in flight
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    if (!ARST_N_I) cnt_ff <= 6'h00;
    else cnt_ff <= (sf_valid && !sf_last) ? cnt_ff + 6'h01 : 6'h00;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  // Event poll and its first reply byte two cycles on
  sequence ev_reply;
    mf_valid && (fc == FC_START || fc == FC_GROUP || fc == FC_INDIV) ##2 sf_valid;
  endsequence
  a_silent_modes: assert property (mf_valid && fc == FC_START && mf_word[11:9] == 3'h1 |=> !sf_valid [*8])
    else $error("reply to silent poll");
  a_illegal_start: assert property (mf_valid && fc == FC_START &&
    (mf_word[11:8] > MODE_SILENT || mf_word[7:4] > CLASS_MAX) |=> !sf_valid [*8]) else $error("reply to illegal poll");
  a_event_one_word: assert property (ev_reply |-> !sf_last ##1 sf_last) else $error("event frame size");
  a_reply_delay: assert property ($rose(sf_valid) |-> $past(mf_valid, 2)) else $error("reply timing");
  a_frame_length: assert property (sf_last |-> cnt_ff == (fc == FC_MSG ? 6'h1F : 6'h01))
    else $error("frame length");
  a_bytes_packed: assert property (sf_valid && !sf_last |=> sf_valid) else $error("gap in frame");
  a_last_on_byte: assert property (sf_last |-> sf_valid) else $error("last without byte");
  a_idle_zero: assert property (!sf_valid |-> sf_byte == 8'h00) else $error("idle byte not zero");
endmodule
`default_nettype wire

// ==== dv/event_arbitration_msg_test.sv ====
// Bench joining administrator and device over the frame link
`timescale 1ns/1ns
`default_nettype none
module event_arbitration_msg_test;
  import eam_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, en = 1'b1, half = 1'b0;
  logic        can = 1'b0, act = 1'b0, wr = 1'b0, osent = 1'b0, pready, slverr, err, sv, cls, sent;
  logic        hact = 1'b1, sact = 1'b1, canh = 1'b0;
  logic [1:0]  ann = 2'h0, drop = 2'h0, odrop = 2'h0, pend, jnd;
  logic [3:0]  waddr = 4'h0, scope;
  logic [7:0]  paddr = 8'h00, lo_b;
  logic [11:0] own = 12'h000, tgt, tgt_e, pat;
  logic [15:0] hi_w = 16'h0, lo_w = 16'h0, wdata = 16'h0, snk_w, w;
  logic [15:0] mw [16];
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] exp_q[$];
  int          fails = 0, check_count = 0;
  int          n_sent = 0, n_sv = 0;
  eam_link_if link_i ();
  eam_bus_admin eam_bus_admin_i (.CLOCK_I(clk), .ARST_N_I(rst_n), .LINK(link_i), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(slverr));
  eam_device eam_device_i (.CLOCK_I(clk), .ARST_N_I(rst_n), .LINK(link_i), .OWN_NODE_NUMBER_I(own),
    .EVENT_POLL_ENABLE_I(en), .HI_SRC_ACTIVE_I(hact), .HI_SRC_WORD_I(hi_w), .LO_SRC_ACTIVE_I(1'b1),
    .LO_SRC_WORD_I(lo_w), .SINK_ACTIVE_I(sact), .ANNOUNCE_I(ann), .CANCEL_EVENT_BIT_HI_I(canh),
    .CANCEL_EVENT_BIT_LO_I(can), .MSG_SRC_ACTIVE_I(act), .MSG_DROP_ON_SEND_I(drop), .MSG_WR_I(wr),
    .MSG_WR_ADDR_I(waddr), .MSG_WR_DATA_I(wdata), .OTHER_SENT_I(osent), .OTHER_DROP_ON_SEND_I(odrop),
    .EVENT_PENDING_O(pend), .ROUND_JOINED_O(jnd), .EVENT_CLASS_O(cls), .SINK_VALID_O(sv), .SINK_WORD_O(snk_w),
    .MSG_SCOPE_O(scope), .MSG_TARGET_O(tgt), .MSG_SENT_O(sent));
  eam_link_checker eam_link_checker_i (.CLOCK_I(clk), .ARST_N_I(rst_n), .mf_valid(link_i.mf_valid),
    .mf_word(link_i.mf_word), .sf_valid(link_i.sf_valid), .sf_byte(link_i.sf_byte), .sf_last(link_i.sf_last));
  // Bus clock, 50 ns period
  always #25 clk = ~clk;
  // ==========
  // Shared tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Request held until pready is seen high
  task automatic apb(input logic w_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Send one master frame, wait for idle, check reply count
  task automatic poll(input logic [15:0] mf, input int n, input logic [15:0] x = 16'h0, input logic ret = 1'b0);
    logic [31:0] r;
    if (n == 1) exp_q.push_back(x);
    apb(1'b1, REG_CMD, {15'h0, ret, mf}, r);
    r = 32'h1;
    while (r[ST_BUSY] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0, r);
    chk_val(r[ST_TIMEOUT], n == 0);
    chk_val(r[ST_CNT_LSB +: CNT_W], n);
  endtask
  task automatic annc(input logic [1:0] a);
    @(posedge clk);
    ann <= a;
    @(posedge clk);
    ann <= 2'h0;
  endtask
  function automatic logic [15:0] sp(input logic [3:0] m, input logic [3:0] c);
    return {FC_START, m, c, 4'h0};
  endfunction
  // Reply words rebuilt from bytes, low byte first
  always @(posedge clk) begin
    if (link_i.sf_valid === 1'b1) begin
      if (half) chk_val({link_i.sf_byte, lo_b}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
      lo_b <= link_i.sf_byte;
      half <= ~half;
    end
  end
  // Pulse counters for the one-cycle outputs
  always @(posedge clk) begin
    if (sent === 1'b1) n_sent <= n_sent + 1;
    if (sv === 1'b1) n_sv <= n_sv + 1;
  end
  // Cuts a hung run short
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h9C3A0416));
    w = 16'($urandom);
    own <= w[11:0];
    // High event frame names our own message poll, so returning it is a real frame
    hi_w <= {FC_MSG, w[11:0]};
    lo_w <= 16'($urandom);
    tgt_e = 12'($urandom);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    annc(2'h1);
    for (int i = 2; i < 16; i++) begin
      if (i > 3) poll(sp(i[3:0], 4'h0), 0);
      poll(sp(MODE_START, i[3:0]), 0);
    end
    chk_val({cls, jnd}, 3'h0);
    annc(2'h2);
    poll(sp(MODE_SILENT, 4'h1), 0);
    chk_val({cls, jnd}, 3'h6);
    poll(sp(MODE_SWITCH, 4'h0), 0);
    chk_val({cls, jnd}, 3'h2);
    poll(sp(MODE_CONT, 4'h0), 0);
    poll(sp(MODE_CONT, 4'h1), 1, lo_w);
    poll(sp(MODE_START, 4'h0), 1, hi_w);
    chk_val({jnd, snk_w}, {2'h3, hi_w});
    poll({FC_INDIV, own}, 1, hi_w);
    poll({FC_INDIV, own ^ 12'h001}, 0);
    hact <= 1'b0;
    poll({FC_INDIV, own}, 0);
    hact <= 1'b1;
    sact <= 1'b0;
    poll({FC_INDIV, own}, 1, hi_w);
    sact <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pat = (i < 2) ? {11'h7FE, own[0] ^ i[0]} : {1'b0, own[10:1], own[0] ^ i[0]};
      poll({FC_GROUP, pat}, !i[0], hi_w);
    end
    poll({FC_GROUP, 12'hFFE}, 1, hi_w);
    chk_val(n_sv, 6);
    apb(1'b0, REG_EVSINK, 32'h0, rd);
    chk_val(rd, {16'h0, hi_w});
    en <= 1'b0;
    poll({FC_INDIV, own}, 0);
    en <= 1'b1;
    apb(1'b0, 8'h10, 32'h0, rd);
    chk_val({err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 16; i++) begin
      w = (i == 0) ? {tgt_e[7:0], 4'h1, tgt_e[11:8]} : 16'($urandom);
      mw[i] = w;
      exp_q.push_back(w);
      @(posedge clk);
      wr <= 1'b1;
      waddr <= i[3:0];
      wdata <= w;
    end
    @(posedge clk);
    wr <= 1'b0;
    act <= 1'b1;
    drop <= 2'h1;
    poll({FC_MSG, own}, 16);
    chk_val({scope, tgt, pend, jnd}, {4'h1, tgt_e, 4'hA});
    // Administrator sends the stored event frame back as a master frame
    foreach (mw[i]) exp_q.push_back(mw[i]);
    poll(16'h0, 16, 16'h0, 1'b1);
    apb(1'b0, REG_CMD, 32'h0, rd);
    chk_val(rd, {16'h0, hi_w});
    apb(1'b0, REG_LASTWORD, 32'h0, rd);
    chk_val(rd, {16'h0, mw[15]});
    chk_val(n_sent, 2);
    annc(2'h3);
    can <= 1'b1;
    odrop <= 2'h1;
    osent <= 1'b1;
    @(posedge clk);
    can <= 1'b0;
    osent <= 1'b0;
    repeat (2) @(posedge clk);
    chk_val({pend, jnd}, 4'h0);
    // Announce meets cancel in one cycle, then the other class is cancelled alone
    ann <= 2'h3;
    can <= 1'b1;
    @(posedge clk);
    ann <= 2'h0;
    can <= 1'b0;
    canh <= 1'b1;
    @(posedge clk);
    canh <= 1'b0;
    repeat (2) @(posedge clk);
    chk_val(pend, 2'h2);
    summarize();
  end
endmodule
`default_nettype wire
